// file: src/hv_channel_supervisor.v
// One high-voltage channel supervisor: setpoint source, ramp engine and protection logic.
// Assumes switches and fault lines are asynchronous; bus strobes come from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "hv_supervisor_regs.vh"

module hv_channel_supervisor #(
	parameter integer VW = 16,
	parameter integer VMAX_FULL = 6000,
	parameter integer IMAX_FULL = 1000,
	parameter integer RAMP_TICK_CYCLES = `RAMP_TICK_CYCLES,
	parameter integer DIAL_SAMPLE_CYCLES = `DIAL_SAMPLE_CYCLES
) (
	// Clock and reset.
	input wire core_clk,
	input wire resetn,
	// Front-panel switches and pins.
	input wire output_on_switch,
	input wire manual_select,
	input wire hard_shutdown_select,
	input wire polarity_pos_end,
	input wire polarity_neg_end,
	input wire external_shutdown_input_n,
	input wire [3:0] vmax_dial,
	input wire [3:0] imax_dial,
	input wire [VW-1:0] pot_setpoint,
	// Converter measurements and fault lines.
	input wire [VW-1:0] meas_voltage,
	input wire [VW-1:0] meas_current,
	input wire regulation_quality_fault,
	input wire limit_exceeded_fault,
	// Bus command strobes, one cycle each.
	input wire wr_setpoint,
	input wire wr_ramp,
	input wire wr_trip,
	input wire wr_auto_start,
	input wire [VW-1:0] wr_data,
	input wire cmd_start,
	input wire cmd_zero,
	input wire rd_status,
	// Auto start flag kept from the previous session.
	input wire auto_start_saved,
	// Outputs.
	output reg [VW-1:0] dac_setpoint,
	output reg [VW-1:0] remote_setpoint,
	output reg [7:0] ramp_rate,
	output reg [VW-1:0] trip_level,
	output reg auto_start,
	output reg [VW-1:0] vmax_limit,
	output reg [VW-1:0] imax_limit,
	output reg error_led,
	output reg error_status,
	output reg zero_status,
	output reg in_change,
	output reg rising,
	output reg trip_fired,
	output reg external_shutdown_seen,
	output reg range_fault,
	output reg latched_off
);

	function [VW-1:0] dial_scale;
		input [3:0] dial;
		input integer full;
		reg [3:0] d;
		integer prod;
		begin
			d = (dial > `DIAL_FULL) ? `DIAL_FULL : dial;
			prod = full * d / 10;
			dial_scale = prod[VW-1:0];
		end
	endfunction

	function near_limit;
		input [VW-1:0] val;
		input [VW-1:0] lim;
		begin
			near_limit = (val * 100) >= (lim * `NEAR_MARGIN_PCT);
		end
	endfunction

	// Two-flop synchronisers for all panel switches, the shutdown pin and both fault lines.
	localparam integer NS = 8;
	wire [NS-1:0] async_in = {output_on_switch, manual_select, hard_shutdown_select, polarity_pos_end,
		polarity_neg_end, external_shutdown_input_n, regulation_quality_fault, limit_exceeded_fault};
	reg [NS-1:0] sync_a;
	reg [NS-1:0] sync_b;
	reg [NS-1:0] sync_prev;
	// The shutdown input idles high; resetting to that level avoids a false shutdown after reset.
	localparam [NS-1:0] SYNC_IDLE = 8'h04;
	always @(posedge core_clk) begin
		if (!resetn) begin
			sync_a <= SYNC_IDLE;
			sync_b <= SYNC_IDLE;
			sync_prev <= SYNC_IDLE;
		end else begin
			sync_a <= async_in;
			sync_b <= sync_a;
			sync_prev <= sync_b;
		end
	end
	wire on_sw = sync_b[7];
	wire manual = sync_b[6];
	wire hard_sel = sync_b[5];
	wire pol_ok = sync_b[4] ^ sync_b[3];
	wire ext_shut = ~sync_b[2];
	wire reg_fault = sync_b[1];
	wire lim_fault = sync_b[0];
	wire on_toggled = sync_b[7] ^ sync_prev[7];
	wire hard_toggled = sync_b[5] ^ sync_prev[5];
	wire to_manual = sync_b[6] & ~sync_prev[6];
	wire to_remote = ~sync_b[6] & sync_prev[6];

	// Ramp timebase and dial sampling ticks.
	reg [31:0] tick_cnt;
	reg [31:0] dial_cnt;
	wire tick = (tick_cnt == RAMP_TICK_CYCLES - 1);
	wire dial_tick = (dial_cnt == DIAL_SAMPLE_CYCLES - 1);
	always @(posedge core_clk) begin
		if (!resetn)
			tick_cnt <= 32'h0;
		else
			tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
	end

	always @(posedge core_clk) begin
		if (!resetn)
			dial_cnt <= 32'h0;
		else
			dial_cnt <= dial_tick ? 32'h0 : dial_cnt + 32'h1;
	end

	// Dials are taken a few times per second.
	always @(posedge core_clk) begin
		if (!resetn) begin
			vmax_limit <= {VW{1'b0}};
			imax_limit <= {VW{1'b0}};
		end else if (dial_tick) begin
			vmax_limit <= dial_scale(vmax_dial, VMAX_FULL); // R17 R13
			imax_limit <= dial_scale(imax_dial, IMAX_FULL); // R13
		end
	end

	// Bus-writable settings; writes land even in manual mode and act on the output only in remote, except the trip level, which trips in any mode.
	reg run_remote;
	reg boot_done;
	reg status_read;
	always @(posedge core_clk) begin
		if (!resetn)
			remote_setpoint <= {VW{1'b0}};
		else if (to_remote)
			remote_setpoint <= dac_setpoint; // R5
		else if (wr_setpoint)
			remote_setpoint <= wr_data; // R7 R14
	end

	// Ramp rate is clamped into its legal range; the top of the range is the full byte.
	always @(posedge core_clk) begin
		if (!resetn)
			ramp_rate <= `SW_RAMP_RESET;
		else if (wr_ramp && (wr_data[7:0] < `SW_RAMP_MIN))
			ramp_rate <= `SW_RAMP_MIN; // R6
		else if (wr_ramp)
			ramp_rate <= wr_data[7:0];
	end

	// A trip level of zero disables the current trip.
	always @(posedge core_clk) begin
		if (!resetn)
			trip_level <= {VW{1'b0}};
		else if (wr_trip)
			trip_level <= wr_data; // R8
	end

	// The saved auto start flag is copied in once, right after reset.
	always @(posedge core_clk) begin
		if (!resetn)
			auto_start <= 1'b0;
		else if (wr_auto_start)
			auto_start <= wr_data[0]; // R4
		else if (!boot_done)
			auto_start <= auto_start_saved; // R4
	end

	wire trip_hit = (trip_level != {VW{1'b0}}) && (meas_current > trip_level);
	wire ceiling_hit = lim_fault || (meas_voltage > vmax_limit) || (meas_current > imax_limit);
	wire hard_hit = hard_sel && (ceiling_hit || ext_shut);

	// The first cycle after reset is where a saved auto start is honoured.
	always @(posedge core_clk) begin
		if (!resetn)
			boot_done <= 1'b0;
		else
			boot_done <= 1'b1;
	end

	// Remote run state: started by the bus, by a saved auto start, or by taking over from manual.
	always @(posedge core_clk) begin
		if (!resetn) begin
			run_remote <= 1'b0;
		end else if (!boot_done && auto_start_saved) begin
			run_remote <= 1'b1; // R4
		end else if (cmd_zero || to_manual) begin
			run_remote <= 1'b0; // R18
		end else if (to_remote) begin
			run_remote <= 1'b1; // R5
		end else if (cmd_start && !manual) begin
			run_remote <= 1'b1; // R3 R18
		end
	end

	// A status read arms the recovery path; a fresh fault disarms it until the next read.
	always @(posedge core_clk) begin
		if (!resetn)
			status_read <= 1'b0;
		else if (trip_hit || hard_hit)
			status_read <= 1'b0;
		else if (rd_status)
			status_read <= 1'b1;
	end

	// Shutdown latch; a new fault wins over a release in the same cycle.
	always @(posedge core_clk) begin
		if (!resetn) begin
			latched_off <= 1'b0;
		end else if (trip_hit || hard_hit) begin
			latched_off <= 1'b1; // R8 R10
		end else if (latched_off && hard_sel && (on_toggled || hard_toggled)) begin
			latched_off <= 1'b0; // R11 R15
		end else if (latched_off && !manual && status_read && (cmd_start || auto_start)) begin
			latched_off <= 1'b0; // R9 R11
		end
	end

	// Event flags hold until a status read; an event in the same cycle as the read wins.
	always @(posedge core_clk) begin
		if (!resetn) begin
			trip_fired <= 1'b0;
			external_shutdown_seen <= 1'b0;
		end else begin
			if (trip_hit)
				trip_fired <= 1'b1;
			else if (rd_status)
				trip_fired <= 1'b0;
			if (ext_shut)
				external_shutdown_seen <= 1'b1;
			else if (rd_status)
				external_shutdown_seen <= 1'b0;
		end
	end

	// Target selection: panel switches override the bus.
	reg [VW-1:0] target;
	reg [VW-1:0] step;
	reg enabled;
	always @* begin
		enabled = on_sw && pol_ok && !latched_off && !ext_shut; // R15 R16 R12
		if (manual)
			target = pot_setpoint; // R1 R2
		else
			target = run_remote ? remote_setpoint : {VW{1'b0}}; // R3 R6
		if (!enabled)
			target = {VW{1'b0}};
		if (target > vmax_limit)
			target = vmax_limit; // R12
		step = manual ? `HW_RAMP_V_PER_S : {{(VW-8){1'b0}}, ramp_rate};
	end

	// Ramp engine: whole volts per tick, with the remainder kept in thousandths of a volt.
	reg [15:0] frac;
	reg [15:0] next_frac;
	reg [VW-1:0] inc;
	reg [31:0] acc;
	reg [31:0] whole;
	reg [31:0] rem;
	always @* begin
		acc = {16'h0000, frac} + {16'h0000, step[15:0]};
		whole = acc / `RAMP_TICK_HZ;
		rem = acc % `RAMP_TICK_HZ;
		next_frac = rem[15:0];
		inc = whole[VW-1:0];
	end

	always @(posedge core_clk) begin
		if (!resetn) begin
			dac_setpoint <= {VW{1'b0}};
			frac <= 16'h0;
		end else begin
			if (latched_off || !pol_ok || ext_shut) begin
				dac_setpoint <= {VW{1'b0}}; // R24 R10 R12 R16
				frac <= 16'h0;
			end else if (tick) begin
				frac <= next_frac;
				if (dac_setpoint < target)
					dac_setpoint <= (target - dac_setpoint <= inc) ? target : dac_setpoint + inc; // R23
				else if (dac_setpoint > target)
					dac_setpoint <= (dac_setpoint - target <= inc) ? target : dac_setpoint - inc; // R23
			end
		end
	end

	// Status view of the ramp: moving, and in which direction.
	always @(posedge core_clk) begin
		if (!resetn) begin
			in_change <= 1'b0;
			rising <= 1'b0;
		end else begin
			in_change <= (dac_setpoint != target);
			rising <= (dac_setpoint < target);
		end
	end

	// A remote setpoint beyond the voltage ceiling is reported as a range fault.
	always @(posedge core_clk) begin
		if (!resetn)
			range_fault <= 1'b0;
		else
			range_fault <= remote_setpoint > vmax_limit;
	end

	always @(posedge core_clk) begin
		if (!resetn)
			error_status <= 1'b0;
		else
			error_status <= reg_fault | lim_fault | external_shutdown_seen | range_fault | trip_fired; // R21
	end

	always @(posedge core_clk) begin
		if (!resetn)
			zero_status <= 1'b0;
		else
			zero_status <= (dac_setpoint == {VW{1'b0}}) && (meas_voltage < `ZERO_THRESHOLD_V); // R22
	end

	// The indicator follows live readings, so it lights before a ceiling acts.
	always @(posedge core_clk) begin
		if (!resetn)
			error_led <= 1'b0;
		else
			error_led <= near_limit(meas_voltage, vmax_limit) | near_limit(meas_current, imax_limit); // R19
	end

endmodule
`default_nettype wire

// file: src/hv_supervisor_regs.vh
// Timing counts, limits and reset values for the high-voltage channel supervisor.
// Assumes a 250 MHz core clock; no module is defined here.
// Operation
// R1 - Manual mode with output on ramps setpoint to potentiometer at hardware rate.
// R2 - Switching remote to manual while running uses the same hardware ramp.
// R3 - DAC mode produces no output until a start voltage change command arrives.
// R4 - Stored auto start begins output at power-up with saved setpoint and ramp; the code resets the setpoint to 0 and the ramp to 2 V/s.
// R5 - Manual to remote change loads DAC setpoint with last manual value.
// R6 - Remote mode ramps at bus-programmed rate clamped to 2..255 V/s.
// R7 - Remote setpoint drives a 16-bit DAC per channel.
// R8 - Current above nonzero programmable trip level latches output off.
// R9 - After trip, status read then start restores output; auto start skips start.
// R10 - Hard shutdown latches off without ramp on ceiling or external shutdown.
// R11 - Hard shutdown clears by switch toggle or status read then start command.
// R12 - Soft mode clamps, cuts on external shutdown, ramps back when released.
// R13 - Ceilings come from dials in tenths, ten meaning full scale.
// R14 - Manual mode accepts bus writes but they never change output; the code still lets a trip level write trip the output in manual mode.
// R15 - Front-panel switches prevail over bus control actions.
// R16 - Polarity selector between end positions yields no output.
// R17 - Ceiling dials are resampled several times per second.
// R18 - Bus offers switch-on to setpoint and switch-to-zero per channel.
// R19 - Error indicator lights when voltage or current nears its ceiling.
// R20 - Operator should use slow ramps or late hard shutdown on capacitive loads.
// R21 - Error status is OR of regulation, limit, shutdown, range and trip flags.
// R22 - Zero status needs DAC setpoint zero and measured voltage below 5 V.
// R23 - Ramp steps setpoint by rate increment per tick, stopping exactly at target.
// R24 - Latched shutdown forces ramp setpoint to zero so restart ramps from zero.
`ifndef HV_SUPERVISOR_REGS_VH
`define HV_SUPERVISOR_REGS_VH

`define CLK_HZ 250000000
`define RAMP_TICK_HZ 1000
`define RAMP_TICK_CYCLES (`CLK_HZ / `RAMP_TICK_HZ)
`define HW_RAMP_V_PER_S 16'h01f4
`define SW_RAMP_MIN 8'h02
`define SW_RAMP_MAX 8'hff
`define DIAL_SAMPLE_HZ 8
`define DIAL_SAMPLE_CYCLES (`CLK_HZ / `DIAL_SAMPLE_HZ)
`define ZERO_THRESHOLD_V 16'h0005
`define NEAR_MARGIN_PCT 95
`define DIAL_FULL 4'ha
`define SW_RAMP_RESET 8'h02

`endif

// file: testbench/hv_channel_supervisor_assertions.sv
// Port checker for the supervisor, bound to every instance.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module hv_channel_supervisor_assertions #(parameter integer VW = 16) (
	// Clock and reset.
	input wire core_clk,
	input wire resetn,
	// Inputs.
	input wire polarity_pos_end,
	input wire polarity_neg_end,
	input wire hard_shutdown_select,
	input wire cmd_start,
	input wire external_shutdown_input_n,
	input wire [VW-1:0] meas_current,
	input wire wr_trip,
	input wire [VW-1:0] wr_data,
	// Outputs.
	input wire [VW-1:0] dac_setpoint,
	input wire [VW-1:0] trip_level,
	input wire error_status,
	input wire zero_status,
	input wire trip_fired,
	input wire auto_start,
	input wire latched_off
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	chk_trip_latch: assert property (trip_level != 0 && meas_current > trip_level |-> ##[1:3] latched_off)
		else $error("trip not latched");
	chk_off_zero: assert property (latched_off [*2] |-> dac_setpoint == 0)
		else $error("output live while off");
	chk_err_or: assert property (trip_fired [*2] |-> error_status)
		else $error("error bit missing");
	chk_zero_flag: assert property ((dac_setpoint != 0) [*2] |-> !zero_status)
		else $error("zero flag with output");
	chk_pol_none: assert property ((!polarity_pos_end && !polarity_neg_end) [*6] |-> dac_setpoint == 0)
		else $error("output with open polarity");
	chk_ext_cut: assert property ((!external_shutdown_input_n) [*6] |-> dac_setpoint == 0)
		else $error("output during shutdown");
	chk_trip_store: assert property (wr_trip |=> trip_level == $past(wr_data))
		else $error("trip level not stored");
	chk_trip_hold: assert property ((!hard_shutdown_select) [*4] ##0 (latched_off && !cmd_start && !auto_start) |=> latched_off)
		else $error("trip released early");
endmodule
bind hv_channel_supervisor hv_channel_supervisor_assertions #(.VW(VW)) chk_u (.core_clk, .resetn,
	.polarity_pos_end, .polarity_neg_end, .hard_shutdown_select, .cmd_start, .external_shutdown_input_n,
	.meas_current, .wr_trip, .wr_data, .dac_setpoint, .trip_level, .error_status, .zero_status, .trip_fired,
	.auto_start, .latched_off);
`default_nettype wire

// file: testbench/bus_ctrl_model.sv
// Bus controller model: raises one command strobe for one clock at a time.
// Assumes the supervisor takes a strobe on a rising core_clk edge.
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
	// Clock.
	input wire logic core_clk,
	// Strobes and data.
	output logic wr_setpoint,
	output logic wr_ramp,
	output logic wr_trip,
	output logic wr_auto_start,
	output logic cmd_start,
	output logic cmd_zero,
	output logic rd_status,
	output logic [15:0] wr_data
);
	initial {wr_setpoint, wr_ramp, wr_trip, wr_auto_start, cmd_start, cmd_zero, rd_status, wr_data} = '0;
	// Strobe k counts from set, ramp, trip, auto, start, zero to status read.
	task automatic op(input int k, input logic [15:0] d);
		@(posedge core_clk);
		wr_data <= d;
		{wr_setpoint, wr_ramp, wr_trip, wr_auto_start, cmd_start, cmd_zero, rd_status} <= 7'h40 >> k;
		@(posedge core_clk);
		{wr_setpoint, wr_ramp, wr_trip, wr_auto_start, cmd_start, cmd_zero, rd_status} <= 7'h00;
	endtask
endmodule
`default_nettype wire

// file: testbench/hv_channel_supervisor_test.sv
// Self-checking bench for one supervisor channel driven by the bus model.
// Assumes shortened tick and dial counts; the checker is bound to the design.
`timescale 1ns/1ps
`default_nettype none
module hv_channel_supervisor_test;
	logic core_clk = 1'b0, resetn = 1'b0, output_on_switch = 1'b1, manual_select = 1'b0;
	logic hard_shutdown_select = 1'b0, polarity_pos_end = 1'b1, external_shutdown_input_n = 1'b1;
	logic [3:0] vmax_dial = 4'h5, imax_dial = 4'ha;
	logic [15:0] pot_setpoint = 16'h0, meas_current = 16'h0, wr_data;
	logic wr_setpoint, wr_ramp, wr_trip, wr_auto_start, cmd_start, cmd_zero, rd_status;
	logic [15:0] dac_setpoint, remote_setpoint, vmax_limit, imax_limit;
	logic [7:0] ramp_rate;
	logic latched_off, trip_fired, error_led, error_status, zero_status;
	logic polarity_neg_end = 1'b0;
	logic [15:0] meas_voltage = 16'h0;
	int n_fail = 0, tests_run = 0;
	always #2 core_clk = ~core_clk;
	bus_ctrl_model ctl_u (.core_clk, .wr_setpoint, .wr_ramp, .wr_trip, .wr_auto_start, .cmd_start, .cmd_zero,
		.rd_status, .wr_data);
	hv_channel_supervisor #(.RAMP_TICK_CYCLES(10), .DIAL_SAMPLE_CYCLES(20)) dut_u (.core_clk, .resetn,
		.output_on_switch, .manual_select, .hard_shutdown_select, .polarity_pos_end, .polarity_neg_end,
		.external_shutdown_input_n, .vmax_dial, .imax_dial, .pot_setpoint, .meas_voltage,
		.meas_current, .regulation_quality_fault(1'b0), .limit_exceeded_fault(1'b0), .wr_setpoint, .wr_ramp,
		.wr_trip, .wr_auto_start, .wr_data, .cmd_start, .cmd_zero, .rd_status, .auto_start_saved(1'b0),
		.dac_setpoint, .remote_setpoint, .ramp_rate, .trip_level(), .auto_start(), .vmax_limit, .imax_limit,
		.error_led, .error_status, .zero_status, .in_change(), .rising(), .trip_fired,
		.external_shutdown_seen(), .range_fault(), .latched_off);
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Waits a bounded span for the ramp to land on its target.
	task automatic settle(input logic [15:0] v);
		for (int i = 0; i < 1500 && dac_setpoint !== v; i++)
			@(posedge core_clk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		cyc(6);
		resetn <= 1'b1;
		cyc(60);
		chk("vmax", 16'h0bb8, vmax_limit);
		chk("imax", 16'h03e8, imax_limit);
		chk("zero", 16'h1, {15'h0, zero_status});
		chk("err", 16'h0, {15'h0, error_status});
		ctl_u.op(1, 16'h0001);
		cyc(2);
		chk("rate", 16'h0002, {8'h0, ramp_rate});
		ctl_u.op(1, 16'h00ff);
		ctl_u.op(0, 16'h0014);
		cyc(100);
		chk("rate", 16'h00ff, {8'h0, ramp_rate});
		chk("remote", 16'h0014, remote_setpoint);
		chk("dac", 16'h0, dac_setpoint);
		ctl_u.op(4, 16'h0);
		cyc(200);
		chk("slow", 16'h1, {15'h0, dac_setpoint <= 16'h0006});
		settle(16'h0014);
		cyc(100);
		chk("dac", 16'h0014, dac_setpoint);
		ctl_u.op(2, 16'h0064);
		meas_current <= 16'h0096;
		cyc(10);
		chk("off", 16'h1, {15'h0, latched_off});
		chk("trip", 16'h1, {15'h0, trip_fired});
		chk("dac", 16'h0, dac_setpoint);
		meas_current <= 16'h0;
		cyc(5);
		ctl_u.op(6, 16'h0);
		ctl_u.op(4, 16'h0);
		cyc(300);
		chk("off", 16'h0, {15'h0, latched_off});
		chk("low", 16'h1, {15'h0, dac_setpoint > 0 && dac_setpoint <= 16'h0008});
		settle(16'h0014);
		pot_setpoint <= 16'h001e;
		manual_select <= 1'b1;
		cyc(100);
		chk("hw", 16'h1, {15'h0, dac_setpoint > 16'h0015 && dac_setpoint < 16'h001d});
		ctl_u.op(0, 16'h0028);
		ctl_u.op(4, 16'h0);
		cyc(300);
		chk("manual", 16'h001e, dac_setpoint);
		manual_select <= 1'b0;
		cyc(10);
		chk("remote", 16'h001e, remote_setpoint);
		external_shutdown_input_n <= 1'b0;
		cyc(10);
		chk("cut", 16'h0, dac_setpoint);
		external_shutdown_input_n <= 1'b1;
		cyc(300);
		chk("back", 16'h1, {15'h0, dac_setpoint > 0});
		polarity_pos_end <= 1'b0;
		cyc(10);
		chk("pol", 16'h0, dac_setpoint);
		polarity_pos_end <= 1'b1;
		hard_shutdown_select <= 1'b1;
		cyc(10);
		external_shutdown_input_n <= 1'b0;
		cyc(10);
		chk("off", 16'h1, {15'h0, latched_off});
		external_shutdown_input_n <= 1'b1;
		cyc(50);
		chk("held", 16'h0, dac_setpoint);
		output_on_switch <= 1'b0;
		cyc(10);
		output_on_switch <= 1'b1;
		cyc(10);
		chk("off", 16'h0, {15'h0, latched_off});
		meas_voltage <= 16'h0b54;
		cyc(5);
		chk("led", 16'h1, {15'h0, error_led});
		chk("err", 16'h1, {15'h0, error_status});
		meas_voltage <= 16'h0;
		polarity_neg_end <= 1'b1;
		cyc(10);
		chk("pol", 16'h0, dac_setpoint);
		polarity_neg_end <= 1'b0;
		tally_and_finish();
	end
	initial begin
		#100000;
		n_fail++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
